// ---- dv/eight_bit_reload_timer_bench.sv ----
// Bench: directed scenarios for the reload timer
`timescale 1ns/1ps
`default_nettype none
module eight_bit_reload_timer_bench;
  import ert_pkg::*;
  logic ref_clk_i = 0, nrst_i = 0, sys_tick_i = 1, sub_tick_i = 0;
  logic powered_down_i = 0, wr_i = 0, rd_i = 0, irq_o, wakeup_o, overflow_o;
  // Wake-up level captured beside the overflow pulse it belongs to
  logic wk = 0;
  logic [ADDR_W-1:0] addr_i = 0;
  logic [DATA_W-1:0] wdata_i = 0, rdata_o;
  int   n_fail = 0, comparisons = 0, cyc = 0, n0;
  ert_timer uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .sys_tick_i(sys_tick_i), .sub_tick_i(sub_tick_i),
    .powered_down_i(powered_down_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .wakeup_o(wakeup_o), .overflow_o(overflow_o));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // Watchdog: the slowest scenario needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge ref_clk_i);
    wr_i <= 0;
    @(posedge ref_clk_i);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1;
    @(posedge ref_clk_i);
    rd_i <= 0;
    @(negedge ref_clk_i);
    chk(rdata_o, e);
    @(posedge ref_clk_i);
  endtask
  task automatic wov(output int n);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (overflow_o !== 1'b1 && n < 600);
    wk = wakeup_o;
    @(posedge ref_clk_i);
  endtask
  // Preload fe while stopped so every run starts two ticks from overflow
  task automatic run(input logic [7:0] ctl, output int n);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT, 8'hfe);
    wr(ADDR_CONTROL, ctl);
    wov(n);
  endtask
  task automatic t_regs;
    rdc(ADDR_CONTROL, CTL_RESET);
    wr(ADDR_CONTROL, 8'hff);
    rdc(ADDR_CONTROL, CTL_WMASK);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT, 8'hfd);
    rdc(ADDR_COUNT, 8'hfd);
    rdc(4'h9, ZERO8);
  endtask
  task automatic t_prescale;
    int n;
    run(8'h10, n0);
    for (int k = 1; k < 8; k++) begin
      run(8'h10 | 8'(k), n);
      chk(8'(n - n0), 8'(2 * ((1 << k) - 1)));
    end
  endtask
  task automatic t_source;
    int n;
    sys_tick_i <= 0;
    sub_tick_i <= 1;
    powered_down_i <= 1;
    run(8'h30, n);
    chk(8'(n), 8'(n0));
    chk({7'h00, wk}, 8'h01);
    powered_down_i <= 0;
  endtask
  task automatic t_irq;
    wr(ADDR_MASK, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    rdc(ADDR_STATUS, ZERO8);
  endtask
  task automatic t_reload;
    int n;
    sys_tick_i <= 1;
    run(8'h17, n);
    wr(ADDR_COUNT, 8'h80);
    rdc(ADDR_COUNT, 8'hfe);
    wov(n);
    rdc(ADDR_COUNT, 8'h80);
  endtask
  task automatic tally_and_finish;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1;
    t_regs();
    t_prescale();
    t_source();
    t_irq();
    t_reload();
    tally_and_finish();
  end
endmodule // eight_bit_reload_timer_bench
`default_nettype wire

// ---- dv/ert_timer_asserts.sv ----
// Checker: port-level properties of the reload timer
`timescale 1ns/1ps
`default_nettype none
module ert_timer_asserts
  import ert_pkg::*;
(
  // Watched ports
  input wire logic              ref_clk_i,
  input wire logic              nrst_i,
  input wire logic              powered_down_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              rd_i,
  input wire logic              wr_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              irq_o,
  input wire logic              wakeup_o,
  input wire logic              overflow_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_ovf_one_pulse: assert property (overflow_o |=> !overflow_o)
    else $error("overflow pulse too long");
  a_wake_with_ovf: assert property (wakeup_o |-> overflow_o)
    else $error("wake-up without overflow");
  a_wake_when_down: assert property
    (overflow_o && $past(powered_down_i) |-> wakeup_o)
    else $error("overflow in power-down did not wake");
  a_irq_sticky: assert property (irq_o && !wr_i |=> irq_o)
    else $error("interrupt dropped without a write");
  a_ctl_unused: assert property
    (rd_i && addr_i == ADDR_CONTROL |=> (rdata_o & ~CTL_WMASK) == ZERO8)
    else $error("unused control bits read nonzero");
  a_sts_unused: assert property
    (rd_i && addr_i == ADDR_STATUS |=> rdata_o[7:1] == 7'h00)
    else $error("unused status bits read nonzero");
  a_unmapped_zero: assert property
    (rd_i && addr_i > ADDR_MASK |=> rdata_o == ZERO8)
    else $error("unmapped read nonzero");
  a_rst_quiet: assert property
    ($rose(nrst_i) |-> !irq_o && !overflow_o && rdata_o == ZERO8)
    else $error("outputs active out of reset");
  c_ovf: cover property (overflow_o);
  c_wake: cover property (wakeup_o);
  c_irq: cover property (irq_o);
endmodule // ert_timer_asserts
bind ert_timer ert_timer_asserts u_chk (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .powered_down_i(powered_down_i), .addr_i(addr_i),
  .rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .wakeup_o(wakeup_o), .overflow_o(overflow_o));
`default_nettype wire

// ---- verilog/ert_pkg.sv ----
// Package: register map, fields and constants of the 8-bit reload timer
package ert_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PSC_W  = 3;
  localparam int DIV_W  = 7;
  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_COUNT   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 4'h3;
  // Control fields
  localparam int CTL_SRC_BIT = 5;
  localparam int CTL_EN_BIT  = 4;
  localparam int CTL_PSC_LSB = 0;
  localparam logic [DATA_W-1:0] CTL_WMASK = 8'h37;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
  // Status and mask fields, full count and zero constants
  localparam int STS_OVF_BIT = 0;
  localparam logic [DATA_W-1:0] STS_WMASK = 8'h01;
  localparam logic [DATA_W-1:0] CNT_FULL  = 8'hff;
  localparam logic [DATA_W-1:0] ZERO8     = 8'h00;
endpackage : ert_pkg

// ---- verilog/ert_prescaler.sv ----
// Prescaler: divides the selected source enable by 2 to the select code
`timescale 1ns/1ps
`default_nettype none
module ert_prescaler
  import ert_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             clear_i,
  input  wire logic             src_tick_i,
  input  wire logic [PSC_W-1:0] prescale_select_i,
  // Output
  output logic                  tick_o
);
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] div_mask;

  // Terminal mask: 2^code - 1
  assign div_mask = DIV_W'((1 << prescale_select_i) - 1);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || clear_i) begin
      div_cnt <= '0;
    end else if (src_tick_i) begin
      if (div_cnt == div_mask) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // Ratio of 2 to the code: terminal count reached on a source tick
  assign tick_o = src_tick_i && !clear_i && (div_cnt == div_mask);
endmodule : ert_prescaler
`default_nettype wire

// ---- verilog/ert_timer.sv ----
// Top: 8-bit reload timer with register port and interrupt
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ert_timer
  import ert_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Clock sources as one-cycle enables
  input  wire logic              sys_tick_i,
  input  wire logic              sub_tick_i,
  // Power state
  input  wire logic              powered_down_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // Events
  output logic                   irq_o,
  output logic                   wakeup_o,
  output logic                   overflow_o
);
  import ert_pkg::*;

  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] preload;
  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] mask;
  logic              count_enable;
  logic              clock_source_select;
  logic [PSC_W-1:0]  prescale_select;
  logic              prescaler_input_clock;
  logic              int_tick;
  logic              access_block;
  logic              count_step;
  logic              ovf;
  logic              wr_count;
  logic              wr_ctl;
  logic              wr_sts;
  logic              wr_mask;

  assign clock_source_select = control[CTL_SRC_BIT];
  assign count_enable        = control[CTL_EN_BIT];
  assign prescale_select     = control[CTL_PSC_LSB +: PSC_W];

  assign wr_count = wr_i && (addr_i == ADDR_COUNT);
  assign wr_ctl   = wr_i && (addr_i == ADDR_CONTROL);
  assign wr_sts   = wr_i && (addr_i == ADDR_STATUS);
  assign wr_mask  = wr_i && (addr_i == ADDR_MASK);

  // Source mux
  assign prescaler_input_clock = clock_source_select ? sub_tick_i
                                                     : sys_tick_i;

  ert_prescaler u_psc (
    .ref_clk_i         (ref_clk_i),
    .nrst_i            (nrst_i),
    .clear_i           (!count_enable),
    .src_tick_i        (prescaler_input_clock),
    .prescale_select_i (prescale_select),
    .tick_o            (int_tick)
  );

  // Access to the count register gates the pulse; that count is lost
  assign access_block = (rd_i || wr_i) && (addr_i == ADDR_COUNT);
  assign count_step   = count_enable && int_tick && !access_block;
  assign ovf          = count_step && (count == CNT_FULL);

  // Preload register
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      preload <= ZERO8;
    end else if (wr_count) begin
      preload <= wdata_i;
    end
  end

  // Counter
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      count <= ZERO8;
    end else if (wr_count && !count_enable) begin
      count <= wdata_i;
    end else if (ovf) begin
      count <= preload;
    end else if (count_step) begin
      count <= count + 1'b1;
    end
  end

  // Control register
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      control <= CTL_RESET;
    end else if (wr_ctl) begin
      control <= wdata_i & CTL_WMASK;
    end
  end

  // Status: overflow set beats a write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      status <= ZERO8;
    end else begin
      status <= ((status & ~(wr_sts ? wdata_i : ZERO8))
                 | {{(DATA_W-1){1'b0}}, ovf}) & STS_WMASK;
    end
  end

  // Mask acts as the interrupt enable
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mask <= ZERO8;
    end else if (wr_mask) begin
      mask <= wdata_i & STS_WMASK;
    end
  end

  // Read data one cycle later; unmapped reads as zero
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= ZERO8;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_COUNT:   rdata_o <= count;
        ADDR_CONTROL: rdata_o <= control;
        ADDR_STATUS:  rdata_o <= status;
        ADDR_MASK:    rdata_o <= mask;
        default:      rdata_o <= ZERO8;
      endcase
    end else begin
      rdata_o <= ZERO8;
    end
  end

  // Event outputs, registered one-cycle pulses
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      overflow_o <= 1'b0;
      wakeup_o   <= 1'b0;
    end else begin
      overflow_o <= ovf;
      wakeup_o   <= ovf && powered_down_i;
    end
  end

  assign irq_o = |(status & mask);
endmodule : ert_timer
`default_nettype wire
